// ===== verilog/sbt_tap.sv
// boundary-scan test port instruction logic for a synchronous memory
// assumes test pins arrive asynchronously and are sampled by core_clk
`timescale 1ns/1ps
// What this block does
// - external test captures like sample
// - external test floats memory outputs
// - identification loads fixed 32-bit code
// - identification register shifts between data pins
// - identification active at reset
// - high-z sample routes boundary register
// - high-z sample floats memory outputs
// - sample captures input and bidirectional balls
// - boundary register shifts after sample capture
// - update under sample changes nothing
// - bypass puts single bit in path
// - instruction register three bits wide
// - capture instruction loads binary 01
// - boundary length 73 bits; the 54-bit length is defined but unused
// - five high mode edges reset logic
module sbt_tap (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic [sbt_pkg::BSR_W-1:0] ring_in,
  output logic tdo_out,
  output logic tdo_oe_n,
  output logic mem_hiz
);
  logic [1:0] tck_sync_ff, tms_sync_ff, tdi_sync_ff;
  logic tck_prev_ff;
  sbt_pkg::sbt_state_t state_ff, nxt_state;
  logic [sbt_pkg::IR_W-1:0] ir_sh_ff, ir_ff;
  logic [sbt_pkg::ID_W-1:0] id_sh_ff;
  logic [sbt_pkg::BSR_W-1:0] bsr_ff;
  logic [sbt_pkg::BSR_W-1:0] ring_meta_ff, ring_sync_ff;
  logic byp_ff;
  logic tdo_ff, oe_n_ff, hiz_ff;

  // two-stage synchronisers
  always_ff @(posedge core_clk)
  begin
    tck_sync_ff <= {tck_sync_ff[0], tck};
    tms_sync_ff <= {tms_sync_ff[0], tms};
    tdi_sync_ff <= {tdi_sync_ff[0], tdi};
    ring_meta_ff <= ring_in;
    ring_sync_ff <= ring_meta_ff;
  end

  // edge detect on the settled tck copy
  always_ff @(posedge core_clk)
  begin
    if (reset)
      tck_prev_ff <= 1'b0;
    else
      tck_prev_ff <= tck_sync_ff[1];
  end

  wire tck_s = tck_sync_ff[1];
  wire tms_s = tms_sync_ff[1];
  wire tdi_s = tdi_sync_ff[1];
  wire rise = tck_s & ~tck_prev_ff;
  wire fall = ~tck_s & tck_prev_ff;
  // decoding; reserved codes fall to bypass path
  wire is_ext = ir_ff == sbt_pkg::IR_EXTEST;
  wire is_id = ir_ff == sbt_pkg::IR_IDCODE;
  wire is_sz = ir_ff == sbt_pkg::IR_SAMPLEZ;
  wire is_smp = ir_ff == sbt_pkg::IR_SAMPLE;
  wire use_bsr = is_ext | is_sz | is_smp;

  // next controller state
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      sbt_pkg::ST_RESET: nxt_state = tms_s ? sbt_pkg::ST_RESET : sbt_pkg::ST_IDLE;
      sbt_pkg::ST_IDLE: nxt_state = tms_s ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_IDLE;
      sbt_pkg::ST_SEL_DR: nxt_state = tms_s ? sbt_pkg::ST_SEL_IR : sbt_pkg::ST_CAP_DR;
      sbt_pkg::ST_CAP_DR: nxt_state = tms_s ? sbt_pkg::ST_EX1_DR : sbt_pkg::ST_SH_DR;
      sbt_pkg::ST_SH_DR: nxt_state = tms_s ? sbt_pkg::ST_EX1_DR : sbt_pkg::ST_SH_DR;
      sbt_pkg::ST_EX1_DR: nxt_state = tms_s ? sbt_pkg::ST_UPD_DR : sbt_pkg::ST_PAU_DR;
      sbt_pkg::ST_PAU_DR: nxt_state = tms_s ? sbt_pkg::ST_EX2_DR : sbt_pkg::ST_PAU_DR;
      sbt_pkg::ST_EX2_DR: nxt_state = tms_s ? sbt_pkg::ST_UPD_DR : sbt_pkg::ST_SH_DR;
      sbt_pkg::ST_UPD_DR: nxt_state = tms_s ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_IDLE;
      sbt_pkg::ST_SEL_IR: nxt_state = tms_s ? sbt_pkg::ST_RESET : sbt_pkg::ST_CAP_IR;
      sbt_pkg::ST_CAP_IR: nxt_state = tms_s ? sbt_pkg::ST_EX1_IR : sbt_pkg::ST_SH_IR;
      sbt_pkg::ST_SH_IR: nxt_state = tms_s ? sbt_pkg::ST_EX1_IR : sbt_pkg::ST_SH_IR;
      sbt_pkg::ST_EX1_IR: nxt_state = tms_s ? sbt_pkg::ST_UPD_IR : sbt_pkg::ST_PAU_IR;
      sbt_pkg::ST_PAU_IR: nxt_state = tms_s ? sbt_pkg::ST_EX2_IR : sbt_pkg::ST_PAU_IR;
      sbt_pkg::ST_EX2_IR: nxt_state = tms_s ? sbt_pkg::ST_UPD_IR : sbt_pkg::ST_SH_IR;
      sbt_pkg::ST_UPD_IR: nxt_state = tms_s ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_IDLE;
    endcase
  end

  // controller state on each tck rise; tms high five rises always reaches reset
  always_ff @(posedge core_clk)
  begin
    if (reset)
      state_ff <= sbt_pkg::ST_RESET;
    else if (rise)
      state_ff <= nxt_state;
  end

  // instruction register: capture 01, shift from msb side, update
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      ir_sh_ff <= sbt_pkg::IR_IDCODE;
      ir_ff <= sbt_pkg::IR_IDCODE;
    end
    else if (rise)
    begin
      if (nxt_state == sbt_pkg::ST_RESET)
        ir_ff <= sbt_pkg::IR_IDCODE;
      else if (state_ff == sbt_pkg::ST_CAP_IR)
        ir_sh_ff <= {ir_sh_ff[sbt_pkg::IR_W-1:2], sbt_pkg::IR_CAPT};
      else if (state_ff == sbt_pkg::ST_SH_IR)
        ir_sh_ff <= {tdi_s, ir_sh_ff[sbt_pkg::IR_W-1:1]};
      else if (state_ff == sbt_pkg::ST_UPD_IR)
        ir_ff <= ir_sh_ff;
    end
  end

  // data registers; update-dr touches nothing since preload is absent
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      id_sh_ff <= '0;
      bsr_ff <= '0;
      byp_ff <= 1'b0;
    end
    else if (rise && state_ff == sbt_pkg::ST_CAP_DR)
    begin
      if (is_id)
        id_sh_ff <= sbt_pkg::ID_VALUE;
      if (use_bsr)
        bsr_ff <= ring_sync_ff;
      byp_ff <= 1'b0;
    end
    else if (rise && state_ff == sbt_pkg::ST_SH_DR)
    begin
      if (is_id)
        id_sh_ff <= {tdi_s, id_sh_ff[sbt_pkg::ID_W-1:1]};
      if (use_bsr)
        bsr_ff <= {tdi_s, bsr_ff[sbt_pkg::BSR_W-1:1]};
      if (!is_id && !use_bsr)
        byp_ff <= tdi_s;
    end
  end // no update-dr branch

  wire shifting = state_ff == sbt_pkg::ST_SH_DR || state_ff == sbt_pkg::ST_SH_IR;
  wire tdo_sel = state_ff == sbt_pkg::ST_SH_IR ? ir_sh_ff[0] :
                 is_id ? id_sh_ff[0] : use_bsr ? bsr_ff[0] : byp_ff;

  // tdo changes on tck fall; enable low while driving
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      tdo_ff <= 1'b0;
      oe_n_ff <= 1'b1;
    end
    else if (fall)
    begin
      tdo_ff <= tdo_sel;
      oe_n_ff <= ~shifting;
    end
  end

  // memory outputs float under external test or high-z sample
  always_ff @(posedge core_clk)
  begin
    if (reset)
      hiz_ff <= 1'b0;
    else
      hiz_ff <= is_ext | is_sz;
  end

  assign tdo_out = tdo_ff;
  assign tdo_oe_n = oe_n_ff;
  assign mem_hiz = hiz_ff;

  a_hiz_on: assert property (@(posedge core_clk) disable iff (reset)
    ir_ff == sbt_pkg::IR_EXTEST || ir_ff == sbt_pkg::IR_SAMPLEZ |=> mem_hiz)
    else $error("memory outputs not floated");
  a_hiz_off: assert property (@(posedge core_clk) disable iff (reset)
    ir_ff != sbt_pkg::IR_EXTEST && ir_ff != sbt_pkg::IR_SAMPLEZ |=> !mem_hiz)
    else $error("memory outputs floated");
  a_reset_loads_id: assert property (@(posedge core_clk) disable iff (reset)
    rise && nxt_state == sbt_pkg::ST_RESET |=> ir_ff == sbt_pkg::IR_IDCODE)
    else $error("reset did not select id");
  a_capir_pattern: assert property (@(posedge core_clk) disable iff (reset)
    rise && state_ff == sbt_pkg::ST_CAP_IR |=> ir_sh_ff[1:0] == sbt_pkg::IR_CAPT)
    else $error("capture-ir pattern wrong");
  a_id_capture: assert property (@(posedge core_clk) disable iff (reset)
    rise && state_ff == sbt_pkg::ST_CAP_DR && is_id |=> id_sh_ff == sbt_pkg::ID_VALUE)
    else $error("id not captured");
  a_bsr_capture: assert property (@(posedge core_clk) disable iff (reset)
    rise && state_ff == sbt_pkg::ST_CAP_DR && use_bsr |=> bsr_ff == $past(ring_in, 3))
    else $error("ring not captured");
  a_upd_dr_stable: assert property (@(posedge core_clk) disable iff (reset)
    rise && state_ff == sbt_pkg::ST_UPD_DR |=> $stable(bsr_ff) && $stable(mem_hiz))
    else $error("update-dr changed state");
  a_bypass_shift: assert property (@(posedge core_clk) disable iff (reset)
    rise && state_ff == sbt_pkg::ST_SH_DR && ir_ff == sbt_pkg::IR_BYPASS
    |=> byp_ff == $past(tdi_s)) else $error("bypass bit wrong");
  a_tms_reset: assert property (@(posedge core_clk) disable iff (reset)
    rise && tms_s && state_ff == sbt_pkg::ST_SEL_IR |=> state_ff == sbt_pkg::ST_RESET)
    else $error("state walk wrong");
  a_oe_idle: assert property (@(posedge core_clk) disable iff (reset)
    fall && !shifting |=> tdo_oe_n) else $error("tdo driven outside shift");
  c_id_shift: cover property (@(posedge core_clk) rise && state_ff == sbt_pkg::ST_SH_DR && is_id);
  c_sz: cover property (@(posedge core_clk) mem_hiz && is_sz);
  c_upd_ir: cover property (@(posedge core_clk) rise && state_ff == sbt_pkg::ST_UPD_IR);
  c_ext_capture: cover property (@(posedge core_clk) rise && state_ff == sbt_pkg::ST_CAP_DR
    && is_ext);
  c_bypass: cover property (@(posedge core_clk) rise && state_ff == sbt_pkg::ST_SH_DR
    && ir_ff == sbt_pkg::IR_BYPASS);
endmodule

// ===== verilog/sbt_pkg.sv
// constants for the memory boundary-scan test port
// assumes a 40 MHz core clock that oversamples a slower test clock
package sbt_pkg;
  localparam int IR_W = 3;
  localparam int ID_W = 32;
  localparam int BSR_X36 = 73;
  localparam int BSR_X18 = 54;
  localparam int BSR_W = BSR_X36;
  // instruction codes; all-zero is external test
  localparam logic [2:0] IR_EXTEST = 3'h0;
  localparam logic [2:0] IR_IDCODE = 3'h1;
  localparam logic [2:0] IR_SAMPLEZ = 3'h2;
  localparam logic [2:0] IR_SAMPLE = 3'h3;
  localparam logic [2:0] IR_BYPASS = 3'h7;
  localparam logic [1:0] IR_CAPT = 2'h1;
  // arbitrary identification value
  localparam logic [31:0] ID_VALUE = 32'h0a5a5001;
  localparam int RESET_EDGES = 5;
  localparam int TCK_MAX_MHZ = 10;
  localparam int CORE_MHZ = 40;
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR,
    ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } sbt_state_t;
endpackage

// ===== verif/sbt_ctl_model.sv
// model of the outside test controller driving the test port
// assumes core_clk at 40 MHz; test clock idles low between transfers
`timescale 1ns/1ps
module sbt_ctl_model (
  input wire logic core_clk,
  input wire logic tdo_line,
  output logic tck,
  output logic tms,
  output logic tdi
);
  // pulled-up lines idle high, clock stands still
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // one 200 ns test clock period, tms and tdi held around the rise
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    repeat (4) @(posedge core_clk);
    #1 q = tdo_line;
    tck = 1'b1;
    repeat (4) @(posedge core_clk);
    #1 tck = 1'b0;
  endtask
  // walk to shift, move n bits lsb first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [72:0] din,
    output logic [72:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b1, q);
    if (ir)
      step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask
  // five high mode rises, then park in idle
  task automatic tap_reset();
    logic q;
    repeat (5) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask
endmodule

// ===== verif/sbt_tap_tb.sv
// self-checking bench for the boundary-scan test port
// assumes sbt_ctl_model drives the test pins
`timescale 1ns/1ps
module sbt_tap_tb;
  logic core_clk, reset, tck, tms, tdi, tdo_out, tdo_oe_n, mem_hiz, tdo_line;
  logic [sbt_pkg::BSR_W-1:0] ring_in;
  logic [72:0] got;
  int fail_count, tests_run, cycles;
  // tdo floats while its enable is off
  assign tdo_line = tdo_oe_n ? 1'bz : tdo_out;
  sbt_tap dut_u (.core_clk(core_clk), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi),
    .ring_in(ring_in), .tdo_out(tdo_out), .tdo_oe_n(tdo_oe_n), .mem_hiz(mem_hiz));
  sbt_ctl_model ctl_u (.core_clk(core_clk), .tdo_line(tdo_line), .tck(tck), .tms(tms),
    .tdi(tdi));
  // 40 MHz core clock
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic check(input logic [72:0] seen, input logic [72:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (fail_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // load an instruction, check the capture pattern on the way out
  task automatic load_ir(input logic [2:0] code);
    ctl_u.scan(1'b1, 3, {70'h0, code}, got);
    check(got & 73'h3, 73'(sbt_pkg::IR_CAPT));
  endtask
  // identification code shifts out
  task automatic t_idcode();
    ctl_u.scan(1'b0, 32, '1, got);
    check(got, 73'(sbt_pkg::ID_VALUE));
    check(73'(mem_hiz), 73'h0);
  endtask
  // ring captured and shifted out; update leaves the float unchanged
  task automatic t_ring(input logic [2:0] code, input logic hiz, input logic [72:0] pat);
    load_ir(code);
    check(73'(mem_hiz), 73'(hiz));
    ring_in = pat; // ring held steady across capture
    ctl_u.scan(1'b0, 73, ~pat, got);
    check(got, pat);
    check(73'(mem_hiz), 73'(hiz));
  endtask
  // bypass: one captured zero, then tdi one bit late
  task automatic t_bypass();
    load_ir(sbt_pkg::IR_BYPASS);
    ctl_u.scan(1'b0, 4, 73'hb, got);
    check(got, 73'h6);
  endtask
  // five high mode rises drop the float and restore identification
  task automatic t_reset();
    load_ir(sbt_pkg::IR_SAMPLEZ);
    ctl_u.tap_reset();
    check(73'(mem_hiz), 73'h0);
    t_idcode();
  endtask
  // main sequence; reserved codes are never loaded
  initial
  begin
    reset = 1'b1;
    ring_in = '0;
    repeat (4) @(posedge core_clk);
    #1 reset = 1'b0;
    check({71'h0, tdo_oe_n, mem_hiz}, 73'h2);
    ctl_u.tap_reset();
    t_idcode();
    t_ring(sbt_pkg::IR_EXTEST, 1'b1, 73'h1_2345_6789_abcd_ef01_23);
    t_ring(sbt_pkg::IR_SAMPLEZ, 1'b1, 73'h0_fedc_ba98_7654_3210_fe);
    t_ring(sbt_pkg::IR_SAMPLE, 1'b0, 73'h1_5555_aaaa_0f0f_f0f0_3c);
    t_bypass();
    load_ir(sbt_pkg::IR_IDCODE);
    t_idcode();
    t_reset();
    give_verdict();
  end
  // cut a hang short
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      give_verdict();
    end
  end
endmodule
